// >>> common/cps_pkg.sv
// package with constants and carrier types for the configuration sequence control block
package cps_pkg;

  // storage geometry (plain defaults)
  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 8;
  localparam int REV_W        = 2;
  localparam int NUM_REV      = 4;
  localparam int FIFO_DEPTH   = 16;

  // power-on reset hold on the output-enable/reset line
  localparam int POR_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_CYCLES   = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reconfiguration pulse width on config_pulse_n
  localparam int CFG_PULSE_NS = 500;
  localparam int CFG_PULSE_CYCLES = (CFG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // internal oscillator divider: one enable every OSC_DIV cycles
  localparam int OSC_DIV      = 2;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [REV_W-1:0]  REV_RST  = 2'h0;

  // control bits held in the programmable array (non-volatile, set at programming time)
  typedef struct packed {
    logic             use_ext_clk;   // 1: external clock pin, 0: oscillator
    logic             parallel_mode; // busy honoured only in parallel mode
    logic             decompress;    // busy disabled when set
    logic [REV_W-1:0] rev_bits;      // internal revision select
  } cps_ctrl_t;

  // per revision block layout
  typedef struct packed {
    logic              present;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] term_count;
  } cps_rev_t;

  // word leaving toward the target
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cps_word_t;

  localparam int WORD_W = ADDR_W + DATA_W;

endpackage : cps_pkg

// >>> design/cps_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module cps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  // honest flags straight from the occupancy count
  assign in_ready  = (count != DEPTH[PW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointer and count next state
  always_comb begin
    do_wr       = in_valid && in_ready;
    do_rd       = out_valid && out_ready;
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  // register pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset; contents are only read while valid
  always_ff @(posedge clk) begin
    if (do_wr && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : cps_fifo

// >>> design/cps_seq.sv
// configuration sequence control: clock choice, address counter, pin control, cascade
`timescale 1ns/1ps
// Functional notes
// R1: a programmed control bit picks the oscillator or the external clock pin as the source.
// R2: the counter steps on an external clock rise only if selected, chip select low, oe high, cfg high, busy low in parallel mode;
// the code ignores busy in parallel mode when decompress is set.
// R3: while oe/reset is low the counter is held in reset and data and clock out float.
// R4: oe/reset is an open-drain two-way line driven low until power-on reset is done, fixed polarity.
// R5: chip select high means standby, counter reset, data and clock out floating.
// R6: a reconfigure instruction pulses config_pulse_n low through an open-drain driver.
// R7: a rising edge on config_pulse_n samples the revision and loads that revision's start address.
// R8: in parallel mode busy high freezes the counter and data; next data follows the first clock after busy falls;
// the code ignores busy in parallel mode when decompress is set.
// R9: cascade_select_out_n goes low when selected and enabled and past terminal count or no block matches, high otherwise.
// R10: pin_revision_override low takes the revision from the pins, high from the programmed bits.
// R11: the sampled revision stays fixed until the next rising edge of config_pulse_n.
module cps_seq
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST_N,
  // programmed control and storage view
  input  wire cps_pkg::cps_ctrl_t       CTRL,
  input  wire cps_pkg::cps_rev_t [3:0]  REV_MAP,
  output logic [cps_pkg::ADDR_W-1:0]    MEM_ADDR,
  input  wire logic [cps_pkg::DATA_W-1:0] MEM_DATA,
  // target side pins
  input  wire logic                     CLK_EXT,
  input  wire logic                     CHIP_SELECT_LOW,
  input  wire logic                     BUSY,
  input  wire logic                     PIN_REVISION_OVERRIDE,
  input  wire logic [cps_pkg::REV_W-1:0] REVISION_PINS,
  // open-drain output enable / reset
  input  wire logic                     OE_RESET_N_IN,
  output logic                          OE_RESET_N_OUT,
  output logic                          OE_RESET_N_OE,
  // open-drain configuration pulse
  input  wire logic                     CONFIG_PULSE_N_IN,
  output logic                          CONFIG_PULSE_N_OUT,
  output logic                          CONFIG_PULSE_N_OE,
  input  wire logic                     RECONFIG_CMD,
  // data and clock toward the target
  output logic [cps_pkg::DATA_W-1:0]    DATA_OUT,
  output logic                          DATA_OE,
  output logic                          CLOCK_TO_TARGET,
  output logic                          CLOCK_TO_TARGET_OE,
  // cascade and status
  output logic                          CASCADE_SELECT_OUT_N,
  output logic                          STANDBY
);
  import cps_pkg::*;

  localparam int PORW = $clog2(POR_CYCLES + 1);
  localparam int CPW  = $clog2(CFG_PULSE_CYCLES + 1);
  localparam int ODW  = $clog2(OSC_DIV + 1);

  // power-on hold and reconfiguration pulse state
  logic [PORW-1:0] por_cnt;
  logic [PORW-1:0] next_por_cnt;
  logic [CPW-1:0]  cfg_cnt;
  logic [CPW-1:0]  next_cfg_cnt;
  logic            next_oe_drive;
  logic            next_cfg_drive;

  // clock source state
  logic [ODW-1:0]  osc_cnt;
  logic [ODW-1:0]  next_osc_cnt;
  logic            ext_q;
  logic            cfg_q;
  logic            step_tick;
  logic            cfg_rise;

  // sequencing state
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [REV_W-1:0]  rev;
  logic [REV_W-1:0]  next_rev;
  logic              past_tc;
  logic              next_past_tc;
  logic              busy_hold;
  logic              next_busy_hold;
  logic              enabled;
  logic              gate_busy;
  logic              can_step;

  // output staging
  logic              next_cascade_n;
  logic [DATA_W-1:0] next_data;
  logic              next_clk_to;

  // fifo link
  cps_word_t         fifo_in;
  cps_word_t         fifo_out;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic              fifo_push;

  // revision choice: pins or programmed bits
  function automatic logic [REV_W-1:0] pick_rev(input logic ovr, input logic [REV_W-1:0] pins,
                                                input logic [REV_W-1:0] bits);
    pick_rev = ovr ? bits : pins; // R10
  endfunction : pick_rev

  // terminal test against a revision block
  function automatic logic is_past(input cps_rev_t blk, input logic [ADDR_W-1:0] a);
    is_past = !blk.present || (a > blk.term_count);
  endfunction : is_past

  // power-on hold and reconfigure pulse counters
  always_comb begin
    next_por_cnt   = (por_cnt != POR_CYCLES[PORW-1:0]) ? por_cnt + 1'b1 : por_cnt;
    next_oe_drive  = (next_por_cnt != POR_CYCLES[PORW-1:0]); // R4
    next_cfg_cnt   = cfg_cnt;
    if (RECONFIG_CMD && cfg_cnt == '0) begin
      next_cfg_cnt = CFG_PULSE_CYCLES[CPW-1:0];
    end else if (cfg_cnt != '0) begin
      next_cfg_cnt = cfg_cnt - 1'b1;
    end
    next_cfg_drive = (next_cfg_cnt != '0); // R6
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      por_cnt           <= '0;
      cfg_cnt           <= '0;
      OE_RESET_N_OE     <= 1'b1;
      CONFIG_PULSE_N_OE <= 1'b0;
    end else begin
      por_cnt           <= next_por_cnt;
      cfg_cnt           <= next_cfg_cnt;
      OE_RESET_N_OE     <= next_oe_drive;
      CONFIG_PULSE_N_OE <= next_cfg_drive;
    end
  end

  // open-drain lines only ever pull low; polarity fixed
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      OE_RESET_N_OUT     <= 1'b0; // R4
      CONFIG_PULSE_N_OUT <= 1'b0; // R6
    end else begin
      OE_RESET_N_OUT     <= 1'b0;
      CONFIG_PULSE_N_OUT <= 1'b0;
    end
  end

  // clock source: oscillator is a divided enable, external clock is edge-sampled
  always_comb begin
    next_osc_cnt = (osc_cnt == ODW'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
    if (CTRL.use_ext_clk) begin
      step_tick = CLK_EXT && !ext_q; // R1
    end else begin
      step_tick = (osc_cnt == '0); // R1
    end
    cfg_rise = CONFIG_PULSE_N_IN && !cfg_q;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      osc_cnt <= '0;
      ext_q   <= 1'b0;
      cfg_q   <= 1'b1;
    end else begin
      osc_cnt <= next_osc_cnt;
      ext_q   <= CLK_EXT;
      cfg_q   <= CONFIG_PULSE_N_IN;
    end
  end

  // address counter, revision latch, busy hold and cascade
  always_comb begin
    enabled        = !CHIP_SELECT_LOW && OE_RESET_N_IN;
    gate_busy      = CTRL.parallel_mode && !CTRL.decompress; // R8
    can_step       = enabled && CONFIG_PULSE_N_IN && !(gate_busy && BUSY) // R2
                     && fifo_in_ready;
    next_addr      = addr;
    next_rev       = rev;
    next_past_tc   = past_tc;
    next_busy_hold = gate_busy && BUSY; // R8
    if (!enabled) begin
      next_addr    = ADDR_RST; // R3 R5
      next_past_tc = 1'b0;
    end else if (cfg_rise) begin
      next_rev     = pick_rev(PIN_REVISION_OVERRIDE, REVISION_PINS, CTRL.rev_bits); // R7 R11
      next_addr    = REV_MAP[next_rev].start_addr; // R7
      next_past_tc = !REV_MAP[next_rev].present;
    end else if (step_tick && can_step && !past_tc) begin
      next_addr    = addr + 1'b1; // R2
      next_past_tc = is_past(REV_MAP[rev], addr + 1'b1);
    end
    next_cascade_n = !(enabled && (past_tc || !REV_MAP[rev].present)); // R9
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      addr                 <= ADDR_RST;
      rev                  <= REV_RST;
      past_tc              <= 1'b0;
      busy_hold            <= 1'b0;
      CASCADE_SELECT_OUT_N <= 1'b1;
    end else begin
      addr                 <= next_addr;
      rev                  <= next_rev;
      past_tc              <= next_past_tc;
      busy_hold            <= next_busy_hold;
      CASCADE_SELECT_OUT_N <= next_cascade_n;
    end
  end

  // each stepped word enters the fifo; back-pressure stalls the counter above
  always_comb begin
    fifo_push     = enabled && step_tick && can_step && !past_tc && !cfg_rise;
    fifo_in.addr  = addr;
    fifo_in.data  = MEM_DATA;
    fifo_pop      = fifo_out_valid && enabled && !busy_hold && step_tick; // R8
  end

  cps_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .flush     (!enabled || cfg_rise),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // data and clock staging toward the target; data holds while busy
  always_comb begin
    next_data   = fifo_pop ? fifo_out.data : DATA_OUT; // R8
    // pulse only when a word is handed out, so each clock edge carries fresh data
    next_clk_to = fifo_pop; // R2 R8
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      MEM_ADDR           <= ADDR_RST;
      DATA_OUT           <= '0;
      DATA_OE            <= 1'b0;
      CLOCK_TO_TARGET    <= 1'b0;
      CLOCK_TO_TARGET_OE <= 1'b0;
      STANDBY            <= 1'b1;
    end else begin
      MEM_ADDR           <= next_addr;
      DATA_OUT           <= next_data;
      DATA_OE            <= enabled; // R3 R5
      CLOCK_TO_TARGET    <= next_clk_to;
      CLOCK_TO_TARGET_OE <= enabled; // R3 R5
      STANDBY            <= CHIP_SELECT_LOW; // R5
    end
  end

endmodule : cps_seq

// >>> dv/cps_seq_chk.sv
// assertion checker bound to the configuration sequence control block
`timescale 1ns/1ps
module cps_seq_chk
  import cps_pkg::*;
(
  // clock, reset and static setup
  input wire logic                       CLK_SYS,
  input wire logic                       RST_N,
  input wire cps_pkg::cps_ctrl_t         CTRL,
  input wire cps_pkg::cps_rev_t [3:0]    REV_MAP,
  // pins
  input wire logic                       CHIP_SELECT_LOW,
  input wire logic                       BUSY,
  input wire logic                       PIN_REVISION_OVERRIDE,
  input wire logic [cps_pkg::REV_W-1:0]  REVISION_PINS,
  input wire logic                       OE_RESET_N_IN,
  input wire logic                       OE_RESET_N_OE,
  input wire logic                       CONFIG_PULSE_N_IN,
  input wire logic                       CONFIG_PULSE_N_OE,
  // outputs under watch
  input wire logic [cps_pkg::ADDR_W-1:0] MEM_ADDR,
  input wire logic [cps_pkg::DATA_W-1:0] DATA_OUT,
  input wire logic                       DATA_OE,
  input wire logic                       CLOCK_TO_TARGET_OE,
  input wire logic                       CASCADE_SELECT_OUT_N,
  input wire logic                       STANDBY
);
  logic [5:0] por_cnt;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // cycles since reset release, saturating so it never wraps into the hold window
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      por_cnt <= 6'h00;
    else if (por_cnt != 6'h3f)
      por_cnt <= por_cnt + 6'h01;
  end
  a_por_hold: assert property (por_cnt < 6'h26 |-> OE_RESET_N_OE)
    else $error("oe line released too early");
  a_por_free: assert property (por_cnt > 6'h2c |-> !OE_RESET_N_OE)
    else $error("oe line still held after power-on");
  a_oe_float: assert property (!OE_RESET_N_IN |=> !DATA_OE && !CLOCK_TO_TARGET_OE)
    else $error("outputs driven while oe low");
  a_cs_standby: assert property (CHIP_SELECT_LOW |=> STANDBY && !DATA_OE && !CLOCK_TO_TARGET_OE)
    else $error("deselected but not in standby");
  a_cs_clear: assert property (CHIP_SELECT_LOW [*3] |-> MEM_ADDR == ADDR_RST)
    else $error("counter not reset while deselected");
  a_rev_load: assert property ($rose(CONFIG_PULSE_N_IN) && !CHIP_SELECT_LOW && OE_RESET_N_IN
    |-> ##[1:2] MEM_ADDR == REV_MAP[PIN_REVISION_OVERRIDE ? CTRL.rev_bits : REVISION_PINS].start_addr)
    else $error("start address not loaded");
  a_busy_freeze: assert property (BUSY && $past(BUSY) && CTRL.parallel_mode && !CTRL.decompress
    && !CHIP_SELECT_LOW && OE_RESET_N_IN && CONFIG_PULSE_N_IN && $past(CONFIG_PULSE_N_IN)
    |=> $stable(MEM_ADDR) && $stable(DATA_OUT))
    else $error("counter moved while busy");
  a_cfg_pulse: assert property ($rose(CONFIG_PULSE_N_OE)
    |-> CONFIG_PULSE_N_OE [*8] ##13 !CONFIG_PULSE_N_OE)
    else $error("reconfigure pulse length wrong");
  a_cas_release: assert property (CHIP_SELECT_LOW || !OE_RESET_N_IN |=> CASCADE_SELECT_OUT_N)
    else $error("cascade output not released");
endmodule : cps_seq_chk

bind cps_seq cps_seq_chk chk_u (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CTRL(CTRL), .REV_MAP(REV_MAP),
  .CHIP_SELECT_LOW(CHIP_SELECT_LOW), .BUSY(BUSY), .PIN_REVISION_OVERRIDE(PIN_REVISION_OVERRIDE),
  .REVISION_PINS(REVISION_PINS), .OE_RESET_N_IN(OE_RESET_N_IN), .OE_RESET_N_OE(OE_RESET_N_OE),
  .CONFIG_PULSE_N_IN(CONFIG_PULSE_N_IN), .CONFIG_PULSE_N_OE(CONFIG_PULSE_N_OE),
  .MEM_ADDR(MEM_ADDR), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
  .CLOCK_TO_TARGET_OE(CLOCK_TO_TARGET_OE), .CASCADE_SELECT_OUT_N(CASCADE_SELECT_OUT_N),
  .STANDBY(STANDBY));

// >>> dv/cps_seq_tb.sv
// self-checking bench for the configuration sequence control block
`timescale 1ns/1ps
module cps_seq_tb;
  import cps_pkg::*;
  // clock, reset and setup
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  cps_ctrl_t ctrl;
  cps_rev_t [3:0] rev_map;
  // pins and outputs
  logic [ADDR_W-1:0] mem_addr, exp_addr;
  logic [DATA_W-1:0] mem_data, data_out;
  logic [REV_W-1:0]  pins;
  logic clk_ext, cs_high, busy, ovr, oe_in, oe_oe, cfg_in, cfg_oe, rcfg;
  logic data_oe, clk_tgt, clk_tgt_oe, cas_n, standby;
  logic run, slow, busy_en, hold_oe, prog, chk_on;
  int errors = 0;
  int comparisons = 0;
  int nwords = 0;
  int n;

  cps_seq dut_u (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CTRL(ctrl), .REV_MAP(rev_map),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .CLK_EXT(clk_ext),
    .CHIP_SELECT_LOW(cs_high), .BUSY(busy), .PIN_REVISION_OVERRIDE(ovr),
    .REVISION_PINS(pins), .OE_RESET_N_IN(oe_in), .OE_RESET_N_OUT(),
    .OE_RESET_N_OE(oe_oe), .CONFIG_PULSE_N_IN(cfg_in), .CONFIG_PULSE_N_OUT(),
    .CONFIG_PULSE_N_OE(cfg_oe), .RECONFIG_CMD(rcfg), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .CLOCK_TO_TARGET(clk_tgt), .CLOCK_TO_TARGET_OE(clk_tgt_oe),
    .CASCADE_SELECT_OUT_N(cas_n), .STANDBY(standby));
  cps_target_model fpga_u (
    .clk(clk_sys), .run(run), .slow(slow), .busy_en(busy_en), .hold_oe(hold_oe),
    .prog(prog), .dut_oe_oe(oe_oe), .dut_cfg_oe(cfg_oe), .clk_ext(clk_ext),
    .busy(busy), .oe_wire(oe_in), .cfg_wire(cfg_in));

  always #12.5 clk_sys = ~clk_sys;
  // stored contents: mixes both address bytes so a skipped step shows
  function automatic logic [DATA_W-1:0] mem_word(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mem_word
  assign mem_data = mem_word(mem_addr);

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // pulse the configuration line from the target side and restart the stream
  task automatic load_rev(input logic on);
    logic [REV_W-1:0] sel;
    run = 1'b0;
    chk_on = 1'b0;
    prog = 1'b1;
    cyc(4);
    sel = ovr ? ctrl.rev_bits : pins;
    prog = 1'b0;
    cyc(3);
    check(mem_addr === rev_map[sel].start_addr, "start address");
    exp_addr = rev_map[sel].start_addr;
    chk_on = on;
    run = 1'b1;
  endtask : load_rev

  // each word handed out must belong to the next address in order
  always @(negedge clk_sys) begin
    if (chk_on && clk_tgt === 1'b1) begin
      check(data_out === mem_word(exp_addr), "stream word");
      exp_addr = exp_addr + 16'h0001;
      nwords++;
    end
  end

  initial begin
    #500000;
    errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h9c19));
    {cs_high, ovr, rcfg, run, slow, busy_en, hold_oe, prog, chk_on} = '0;
    pins = 2'h0;
    ctrl = '0;
    ctrl.use_ext_clk = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rev_map[i].present = 1'b1;
      rev_map[i].start_addr = 16'($urandom_range(32'h7fff));
      rev_map[i].term_count = rev_map[i].start_addr + 16'h0200;
    end
    rev_map[3].term_count = rev_map[3].start_addr + 16'h0004;
    rev_map[2].present = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    check(oe_oe === 1'b1 && oe_in === 1'b0, "power-on hold");
    cyc(POR_CYCLES + 2);
    check(oe_oe === 1'b0, "power-on release");
    $display("test power_on done");
    // revision choice, busy gating and rates, with pins moving after the sample
    for (int k = 0; k < 8; k++) begin
      ovr = k[0];
      pins = 2'($urandom_range(1));
      ctrl.rev_bits = 2'($urandom_range(1));
      ctrl.parallel_mode = k[1];
      ctrl.decompress = (k == 7);
      busy_en = k[1];
      slow = k[2];
      n = nwords;
      load_rev(1'b1);
      cyc(20);
      pins = ~pins;
      cyc(60);
      busy_en = 1'b0;
      cyc(8);
      check(nwords > n, "stream stalled");
    end
    $display("test revisions done");
    ovr = 1'b0;
    pins = 2'h3;
    load_rev(1'b1);
    for (n = 0; n < 300 && cas_n !== 1'b0; n++) cyc(1);
    check(cas_n === 1'b0 && nwords > 0, "cascade after terminal count");
    cs_high = 1'b1;
    chk_on = 1'b0;
    cyc(4);
    check(cas_n === 1'b1 && standby === 1'b1 && data_oe === 1'b0, "standby");
    check(clk_tgt_oe === 1'b0 && mem_addr === ADDR_RST, "standby counter");
    cs_high = 1'b0;
    pins = 2'h2;
    load_rev(1'b0);
    cyc(10);
    check(cas_n === 1'b0, "cascade on absent revision");
    $display("test cascade done");
    pins = 2'h0;
    load_rev(1'b1);
    cyc(20);
    chk_on = 1'b0;
    hold_oe = 1'b1;
    cyc(4);
    check(data_oe === 1'b0 && clk_tgt_oe === 1'b0 && mem_addr === ADDR_RST, "oe hold");
    hold_oe = 1'b0;
    run = 1'b0;
    rcfg = 1'b1;
    cyc(1);
    rcfg = 1'b0;
    for (n = 0; n < 100 && cfg_in !== 1'b0; n++) cyc(1);
    for (n = 0; n < 100 && cfg_in === 1'b0; n++) cyc(1);
    check(n == CFG_PULSE_CYCLES, "reconfigure pulse");
    $display("test oe_and_reconfigure done");
    cyc(3);
    exp_addr = rev_map[0].start_addr;
    chk_on = 1'b1;
    n = nwords;
    ctrl.use_ext_clk = 1'b0;
    cyc(40);
    check(nwords > n, "oscillator source");
    ctrl.use_ext_clk = 1'b1;
    cyc(10);
    n = nwords;
    cyc(20);
    check(nwords == n, "idle external clock");
    $display("test clock_source done");
    conclude();
  end
endmodule : cps_seq_tb

// >>> dv/cps_target_model.sv
// behavioural model of the target's configuration logic beyond the pins
`timescale 1ns/1ps
module cps_target_model (
  // clock and bench controls
  input  wire logic clk,
  input  wire logic run,
  input  wire logic slow,
  input  wire logic busy_en,
  input  wire logic hold_oe,
  input  wire logic prog,
  // open-drain enables of the block
  input  wire logic dut_oe_oe,
  input  wire logic dut_cfg_oe,
  // pins toward the block
  output logic      clk_ext,
  output logic      busy,
  output logic      oe_wire,
  output logic      cfg_wire
);
  logic [1:0] div = 2'h0;
  // both shared lines have pull-ups: released means high, any driver pulls low
  assign oe_wire  = !(dut_oe_oe || hold_oe);
  assign cfg_wire = !(dut_cfg_oe || prog);
  initial begin
    clk_ext = 1'b0;
    busy = 1'b0;
  end
  // clock stands still low between frames; slow mode cuts its rate by four
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (!run)
      clk_ext <= 1'b0;
    else if (!slow || div == 2'h0)
      clk_ext <= ~clk_ext;
    busy <= busy_en && ($urandom_range(3) == 0);
  end
endmodule : cps_target_model
